// ---- sbc_interrupt_flags_masks.sv ----
// Interrupt flag and mask registers of the system basis chip.
// Assumes event inputs are one-cycle pulses from units on sys_clk, and a register
// port on sys_clk where a write or read lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module sbc_interrupt_flags_masks (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq_out,
  input wire logic watchdog_error_event,
  input wire logic bus_wake_event,
  input wire logic local_wake_event,
  input wire logic selective_wake_timer_expired,
  input wire logic bus_silent_event,
  input wire logic bus_stuck_dominant_event,
  input wire logic regulator_overvoltage_event,
  input wire logic supply_undervoltage_event,
  input wire logic regulator_undervoltage_event,
  input wire logic thermal_shutdown_event,
  input wire logic thermal_warning_event,
  input wire logic serial_error_status_set,
  input wire logic lines_shorted_event,
  input wire logic high_line_battery_event,
  input wire logic low_line_ground_event,
  input wire logic bus_open_event,
  input wire logic bus_ground_short_event,
  input wire logic high_line_ground_event,
  input wire logic bus_battery_short_event,
  input wire logic low_line_battery_event
);
  import sbc_irq_pkg::*;

  logic [7:0] wake_watchdog_flags;
  logic [7:0] supply_thermal_flags;
  logic [7:0] serial_error_flags;
  logic [7:0] bus_fault_flags;
  logic [7:0] wake_watchdog_flag_mask;
  logic [7:0] supply_thermal_flag_mask;
  logic [7:0] set_wake_wd;
  logic [7:0] set_supply;
  logic [7:0] set_serial;
  logic [7:0] set_bus_fault;
  logic [7:0] summary;
  logic [7:0] next_rdata;
  logic next_irq;

  // Set wins over a same-cycle clear so no event is lost
  function automatic logic [7:0] w1c_next(input logic [7:0] flags, input logic hit,
                                          input logic [7:0] wdata, input logic [7:0] set,
                                          input logic [7:0] valid);
    w1c_next = ((flags & ~(hit ? wdata : 8'h00)) | set) & valid;
  endfunction

  function automatic logic wr_hit(input logic [7:0] addr, input logic wr,
                                  input logic [7:0] offset);
    wr_hit = wr && (addr == offset);
  endfunction

  always_comb begin
    set_wake_wd = 8'h00;
    set_wake_wd[B_WATCHDOG] = watchdog_error_event;
    set_wake_wd[B_WAKE_ERROR] = selective_wake_timer_expired;
    set_wake_wd[B_BUS_WAKE] = bus_wake_event;
    set_wake_wd[B_LOCAL_WAKE] = local_wake_event;
    set_wake_wd[B_BUS_SILENT] = bus_silent_event;
    set_wake_wd[B_STUCK_DOMINANT] = bus_stuck_dominant_event;
  end

  always_comb begin
    set_supply = 8'h00;
    set_supply[B_REG_OVERVOLT] = regulator_overvoltage_event;
    set_supply[B_SUPPLY_UNDERVOLT] = supply_undervoltage_event;
    set_supply[B_REG_UNDERVOLT] = regulator_undervoltage_event;
    set_supply[B_THERMAL_SHUTDOWN] = thermal_shutdown_event;
    set_supply[B_THERMAL_WARNING] = thermal_warning_event;
  end

  always_comb begin
    set_serial = 8'h00;
    set_serial[B_SERIAL_ERROR] = serial_error_status_set;
  end

  always_comb begin
    set_bus_fault = 8'h00;
    set_bus_fault[B_LINES_SHORTED] = lines_shorted_event;
    set_bus_fault[B_HIGH_BATTERY] = high_line_battery_event;
    set_bus_fault[B_LOW_GROUND] = low_line_ground_event;
    set_bus_fault[B_BUS_OPEN] = bus_open_event;
    set_bus_fault[B_BUS_GROUND] = bus_ground_short_event | high_line_ground_event;
    set_bus_fault[B_BUS_BATTERY] = bus_battery_short_event | low_line_battery_event;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_watchdog_flags <= RST_WAKE_WD_FLAGS;
    end else begin
      wake_watchdog_flags <= w1c_next(wake_watchdog_flags,
        wr_hit(reg_addr, reg_wr, OFF_WAKE_WD_FLAGS), reg_wdata, set_wake_wd, VALID_WAKE_WD);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      supply_thermal_flags <= RST_SUPPLY_FLAGS;
    end else begin
      supply_thermal_flags <= w1c_next(supply_thermal_flags,
        wr_hit(reg_addr, reg_wr, OFF_SUPPLY_FLAGS), reg_wdata, set_supply, VALID_SUPPLY_FLAGS);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_error_flags <= RST_SERIAL_FLAGS;
    end else begin
      serial_error_flags <= w1c_next(serial_error_flags,
        wr_hit(reg_addr, reg_wr, OFF_SERIAL_FLAGS), reg_wdata, set_serial, VALID_SERIAL);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_fault_flags <= RST_BUS_FAULT_FLAGS;
    end else begin
      // Valid mask keeps bits 7:6 at zero
      bus_fault_flags <= w1c_next(bus_fault_flags,
        wr_hit(reg_addr, reg_wr, OFF_BUS_FAULT_FLAGS), reg_wdata, set_bus_fault, VALID_BUS_FAULT);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_watchdog_flag_mask <= RST_WAKE_WD_MASK;
    end else if (wr_hit(reg_addr, reg_wr, OFF_WAKE_WD_MASK)) begin
      wake_watchdog_flag_mask <= reg_wdata & VALID_WAKE_WD_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      supply_thermal_flag_mask <= RST_SUPPLY_MASK;
    end else if (wr_hit(reg_addr, reg_wr, OFF_SUPPLY_MASK)) begin
      supply_thermal_flag_mask <= reg_wdata & VALID_SUPPLY_MASK;
    end
  end

  always_comb begin
    summary = 8'h00;
    summary[B_SUM_WAKE_WD] = |wake_watchdog_flags;
    summary[B_SUM_SUPPLY] = |supply_thermal_flags;
    summary[B_SUM_SERIAL] = |serial_error_flags;
    summary[B_SUM_BUS_FAULT] = |bus_fault_flags;
    summary[B_SUM_ANY] = summary[B_SUM_WAKE_WD] | summary[B_SUM_SUPPLY] |
                         summary[B_SUM_SERIAL] | summary[B_SUM_BUS_FAULT];
  end

  always_comb begin
    unique case (reg_addr)
      OFF_GLOBAL: next_rdata = summary;
      OFF_WAKE_WD_FLAGS: next_rdata = wake_watchdog_flags;
      OFF_SUPPLY_FLAGS: next_rdata = supply_thermal_flags;
      OFF_SERIAL_FLAGS: next_rdata = serial_error_flags;
      OFF_BUS_FAULT_FLAGS: next_rdata = bus_fault_flags;
      OFF_WAKE_WD_MASK: next_rdata = wake_watchdog_flag_mask;
      OFF_SUPPLY_MASK: next_rdata = supply_thermal_flag_mask;
      default: next_rdata = RDATA_NONE;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= RDATA_NONE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Serial and bus-fault masks live elsewhere, so those groups pass unmasked;
  // power-on has no enable and never raises the output
  always_comb begin
    next_irq = |(wake_watchdog_flags & wake_watchdog_flag_mask) |
               |(supply_thermal_flags & supply_thermal_flag_mask) |
               |serial_error_flags | |bus_fault_flags;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_WATCHDOG_SETS: assert property (
    watchdog_error_event |=> wake_watchdog_flags[B_WATCHDOG])
    else $error("watchdog flag missed an event");
  AST_WAKE_ERROR_SETS: assert property (
    selective_wake_timer_expired |=> wake_watchdog_flags[B_WAKE_ERROR])
    else $error("wake error flag missed timer expiry");
  AST_WAKE_RSVD_ZERO: assert property (
    bus_wake_event |=> wake_watchdog_flags[B_BUS_WAKE] &&
    (wake_watchdog_flags & ~VALID_WAKE_WD) == 8'h00)
    else $error("first flag register layout wrong");
  AST_POWER_ON_HOLDS: assert property (
    supply_thermal_flags[B_POWER_ON] && !(reg_wr && reg_addr == OFF_SUPPLY_FLAGS &&
    reg_wdata[B_POWER_ON]) |=> supply_thermal_flags[B_POWER_ON])
    else $error("power-on flag lost without a clear");
  AST_SERIAL_SETS: assert property (
    serial_error_status_set |=> serial_error_flags == VALID_SERIAL)
    else $error("serial error flag wrong");
  AST_LINES_SHORTED: assert property (
    lines_shorted_event |=> bus_fault_flags[B_LINES_SHORTED])
    else $error("lines shorted flag missed");
  AST_GROUND_MERGE: assert property (
    high_line_ground_event || bus_ground_short_event |=> bus_fault_flags[B_BUS_GROUND])
    else $error("ground short flag missed");
  AST_BATTERY_MERGE: assert property (
    low_line_battery_event || bus_battery_short_event |=> bus_fault_flags[B_BUS_BATTERY])
    else $error("battery short flag missed");
  AST_BUS_FAULT_RSVD: assert property (
    reg_rd && reg_addr == OFF_BUS_FAULT_FLAGS |=> reg_rdata[7:6] == 2'b00)
    else $error("bus fault reserved bits read nonzero");
  AST_W1C_CLEAR: assert property (
    reg_wr && reg_addr == OFF_WAKE_WD_FLAGS && reg_wdata[B_WATCHDOG] && !watchdog_error_event
    |=> !wake_watchdog_flags[B_WATCHDOG] ##1 !wake_watchdog_flags[B_WATCHDOG] || $past(watchdog_error_event))
    else $error("write one did not clear flag");
  // Set wins over a same-cycle clear
  AST_SET_WINS: assert property (
    watchdog_error_event && reg_wr && reg_addr == OFF_WAKE_WD_FLAGS && reg_wdata[B_WATCHDOG]
    |=> wake_watchdog_flags[B_WATCHDOG])
    else $error("clear beat a same-cycle event");
  AST_RDATA_HOLDS: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  AST_W1C_ZERO_KEEPS: assert property (
    wake_watchdog_flags[B_LOCAL_WAKE] && !(reg_wr && reg_addr == OFF_WAKE_WD_FLAGS &&
    reg_wdata[B_LOCAL_WAKE]) |=> wake_watchdog_flags[B_LOCAL_WAKE])
    else $error("flag cleared without a one written");
  // Reset patterns carry ones in reserved mask bits; written values must drop them
  AST_MASK1_RSVD: assert property (
    reg_wr && reg_addr == OFF_WAKE_WD_MASK |=>
    (wake_watchdog_flag_mask & ~VALID_WAKE_WD_MASK) == 8'h00)
    else $error("first mask kept a reserved bit");
  AST_MASK2_RSVD: assert property (
    reg_wr && reg_addr == OFF_SUPPLY_MASK |=>
    (supply_thermal_flag_mask & ~VALID_SUPPLY_MASK) == 8'h00)
    else $error("second mask kept a reserved bit");
  AST_MASK2_TOP_ZERO: assert property (
    reg_rd && reg_addr == OFF_SUPPLY_MASK |=> reg_rdata[7:6] == 2'b00)
    else $error("second mask top bits nonzero");
  AST_SUMMARY: assert property (
    reg_rd && reg_addr == OFF_GLOBAL |=> reg_rdata[B_SUM_ANY] ==
    ($past(|wake_watchdog_flags) || $past(|supply_thermal_flags) ||
     $past(|serial_error_flags) || $past(|bus_fault_flags)))
    else $error("summary bit disagrees with flags");
  AST_SUMMARY_GROUPS: assert property (
    reg_rd && reg_addr == OFF_GLOBAL |=>
    reg_rdata[B_SUM_WAKE_WD] == $past(|wake_watchdog_flags) &&
    reg_rdata[B_SUM_SUPPLY] == $past(|supply_thermal_flags) &&
    reg_rdata[B_SUM_SERIAL] == $past(|serial_error_flags) &&
    reg_rdata[B_SUM_BUS_FAULT] == $past(|bus_fault_flags))
    else $error("summary group bits disagree with flags");
  AST_IRQ_MASKED: assert property (
    watchdog_error_event && wake_watchdog_flag_mask[B_WATCHDOG] |=> ##1 irq_out)
    else $error("enabled flag did not raise interrupt");
  AST_IRQ_QUIET: assert property (
    !(|(wake_watchdog_flags & wake_watchdog_flag_mask)) &&
    !(|(supply_thermal_flags & supply_thermal_flag_mask)) &&
    !(|serial_error_flags) && !(|bus_fault_flags) |=> !irq_out)
    else $error("interrupt raised with no enabled flag");
  // No mask for these two groups here, so any flag reaches the output
  AST_UNMASKED_GROUPS: assert property (
    (|serial_error_flags) || (|bus_fault_flags) |=> irq_out)
    else $error("serial or bus fault flag missed the interrupt");

  COV_SET_AND_CLEAR: cover property (watchdog_error_event && reg_wr &&
    reg_addr == OFF_WAKE_WD_FLAGS && reg_wdata[B_WATCHDOG]);
  COV_IRQ_RISE: cover property (!irq_out ##1 irq_out);
  COV_BUS_FAULT_IRQ: cover property ((|bus_fault_flags) ##1 irq_out);
  COV_POWER_ON_CLEARED: cover property ($fell(supply_thermal_flags[B_POWER_ON]));
  COV_SUMMARY_READ: cover property (reg_rd && reg_addr == OFF_GLOBAL ##1 reg_rdata[B_SUM_ANY]);
endmodule
`default_nettype wire

// ---- sbc_irq_pkg.sv ----
// Register map, field positions and reset values of the interrupt flag block.
// Assumes an 8-bit register address space shared with the serial register port.
package sbc_irq_pkg;
  localparam logic [7:0] OFF_GLOBAL = 8'h50;
  localparam logic [7:0] OFF_WAKE_WD_FLAGS = 8'h51;
  localparam logic [7:0] OFF_SUPPLY_FLAGS = 8'h52;
  localparam logic [7:0] OFF_SERIAL_FLAGS = 8'h53;
  localparam logic [7:0] OFF_BUS_FAULT_FLAGS = 8'h54;
  localparam logic [7:0] OFF_WAKE_WD_MASK = 8'h56;
  localparam logic [7:0] OFF_SUPPLY_MASK = 8'h57;

  localparam logic [7:0] RST_WAKE_WD_FLAGS = 8'h00;
  localparam logic [7:0] RST_SUPPLY_FLAGS = 8'h40;
  localparam logic [7:0] RST_SERIAL_FLAGS = 8'h00;
  localparam logic [7:0] RST_BUS_FAULT_FLAGS = 8'h00;
  localparam logic [7:0] RST_WAKE_WD_MASK = 8'hF3;
  localparam logic [7:0] RST_SUPPLY_MASK = 8'h3F;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // Implemented bits; all others ignore writes and read zero, but reset sets some reserved mask bits
  localparam logic [7:0] VALID_WAKE_WD = 8'hF5;
  localparam logic [7:0] VALID_SUPPLY_FLAGS = 8'h77;
  localparam logic [7:0] VALID_SERIAL = 8'h80;
  localparam logic [7:0] VALID_BUS_FAULT = 8'h3F;
  localparam logic [7:0] VALID_WAKE_WD_MASK = 8'hF5;
  localparam logic [7:0] VALID_SUPPLY_MASK = 8'h37;

  localparam int B_WATCHDOG = 7;
  localparam int B_BUS_WAKE = 6;
  localparam int B_LOCAL_WAKE = 5;
  localparam int B_WAKE_ERROR = 4;
  localparam int B_BUS_SILENT = 2;
  localparam int B_STUCK_DOMINANT = 0;

  localparam int B_POWER_ON = 6;
  localparam int B_REG_OVERVOLT = 5;
  localparam int B_SUPPLY_UNDERVOLT = 4;
  localparam int B_REG_UNDERVOLT = 2;
  localparam int B_THERMAL_SHUTDOWN = 1;
  localparam int B_THERMAL_WARNING = 0;

  localparam int B_SERIAL_ERROR = 7;

  localparam int B_LINES_SHORTED = 5;
  localparam int B_HIGH_BATTERY = 4;
  localparam int B_LOW_GROUND = 3;
  localparam int B_BUS_OPEN = 2;
  localparam int B_BUS_GROUND = 1;
  localparam int B_BUS_BATTERY = 0;

  localparam int B_SUM_ANY = 7;
  localparam int B_SUM_WAKE_WD = 6;
  localparam int B_SUM_SUPPLY = 5;
  localparam int B_SUM_SERIAL = 4;
  localparam int B_SUM_BUS_FAULT = 3;
endpackage

// ---- host_sw_model.sv ----
// Host software model: reads and writes flag and mask registers over the strobe port.
// Assumes the bench calls its tasks; strobes change only at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_sw_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // Software acknowledges an event only by writing a one to its flag
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- sbc_interrupt_flags_masks_tb_top.sv ----
// Self-checking bench for the interrupt flag and mask block.
// Assumes a 40 MHz clock; events and register strobes are driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) check_count++; if ((act) !== (exp)) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, act, exp); end
module sbc_interrupt_flags_masks_tb_top;
  import sbc_irq_pkg::*;
  logic sys_clk, reset_n, reg_wr, reg_rd, irq_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [19:0] ev;
  int n_mismatch = 0;
  int check_count = 0;
  // Each event: register address, then flag bit
  localparam logic [11:0] EV_MAP [20] = '{
    12'h517, 12'h516, 12'h515, 12'h514, 12'h512, 12'h510,
    12'h525, 12'h524, 12'h522, 12'h521, 12'h520,
    12'h537,
    12'h545, 12'h544, 12'h543, 12'h542,
    12'h541, 12'h541,
    12'h540, 12'h540};
  localparam logic [7:0] RST_EXP [8] = '{8'hA0, RST_WAKE_WD_FLAGS, RST_SUPPLY_FLAGS,
    RST_SERIAL_FLAGS, RST_BUS_FAULT_FLAGS, RDATA_NONE, RST_WAKE_WD_MASK, RST_SUPPLY_MASK};

  host_sw_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  sbc_interrupt_flags_masks dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_out(irq_out), .watchdog_error_event(ev[0]), .bus_wake_event(ev[1]),
    .local_wake_event(ev[2]), .selective_wake_timer_expired(ev[3]),
    .bus_silent_event(ev[4]), .bus_stuck_dominant_event(ev[5]),
    .regulator_overvoltage_event(ev[6]), .supply_undervoltage_event(ev[7]),
    .regulator_undervoltage_event(ev[8]), .thermal_shutdown_event(ev[9]),
    .thermal_warning_event(ev[10]), .serial_error_status_set(ev[11]),
    .lines_shorted_event(ev[12]), .high_line_battery_event(ev[13]),
    .low_line_ground_event(ev[14]), .bus_open_event(ev[15]),
    .bus_ground_short_event(ev[16]), .high_line_ground_event(ev[17]),
    .bus_battery_short_event(ev[18]), .low_line_battery_event(ev[19]));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic pulse(input int i);
    @(negedge sys_clk);
    ev[i] = 1'b1;
    @(negedge sys_clk);
    ev[i] = 1'b0;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    `CHK(irq_out, 1'b0)
    for (int i = 0; i < 8; i++) begin
      host.rd(OFF_GLOBAL + 8'(i), d);
      `CHK(d, RST_EXP[i])
    end
  endtask

  // Every event latches only its mapped bit (ground events share one, battery events another); zeros and other ones leave it set
  task automatic t_events();
    logic [7:0] a, d, m;
    host.wr(OFF_SUPPLY_FLAGS, 8'hFF);
    for (int i = 0; i < 20; i++) begin
      a = EV_MAP[i][11:4];
      m = 8'h01 << EV_MAP[i][3:0];
      pulse(i);
      host.rd(a, d);
      `CHK(d, m)
      host.wr(a, ~m);
      host.rd(a, d);
      `CHK(d, m)
      host.wr(a, m);
      host.rd(a, d);
      `CHK(d, 8'h00)
    end
  endtask

  // Masked flag still latches but stays off the interrupt line
  task automatic t_irq(input logic [7:0] ma, input int i, input logic [7:0] mv);
    logic [7:0] a, d;
    a = EV_MAP[i][11:4];
    host.wr(ma, 8'h00);
    pulse(i);
    repeat (3) @(negedge sys_clk);
    `CHK(irq_out, 1'b0)
    host.rd(a, d);
    `CHK(d, mv)
    host.wr(ma, mv);
    repeat (2) @(negedge sys_clk);
    `CHK(irq_out, 1'b1)
    host.wr(a, mv);
    repeat (2) @(negedge sys_clk);
    `CHK(irq_out, 1'b0)
  endtask

  // Event and clear of one flag in the same cycle: the event must survive
  task automatic t_set_wins();
    logic [7:0] d;
    fork
      host.wr(OFF_WAKE_WD_FLAGS, 8'h80);
      pulse(0);
    join
    host.rd(OFF_WAKE_WD_FLAGS, d);
    `CHK(d, 8'h80)
    host.wr(OFF_WAKE_WD_FLAGS, 8'h80);
    host.rd(OFF_WAKE_WD_FLAGS, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_summary();
    logic [7:0] d;
    pulse(15);
    pulse(9);
    host.rd(OFF_GLOBAL, d);
    `CHK(d, 8'hA8)
    host.wr(OFF_BUS_FAULT_FLAGS, 8'h04);
    host.wr(OFF_SUPPLY_FLAGS, 8'h02);
    host.rd(OFF_GLOBAL, d);
    `CHK(d, 8'h00)
  endtask

  // Reserved bits and unmapped places ignore writes
  task automatic t_reserved();
    logic [7:0] d;
    logic [7:0] ad [7] = '{8'h56, 8'h57, 8'h54, 8'h53, 8'h51, 8'h55, 8'h50};
    logic [7:0] wv [7] = '{8'hFF, 8'hFF, 8'hC0, 8'h7F, 8'h0A, 8'hFF, 8'hFF};
    logic [7:0] ex [7] = '{8'hF5, 8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      host.wr(ad[i], wv[i]);
      host.rd(ad[i], d);
      `CHK(d, ex[i])
    end
    host.wr(OFF_SUPPLY_MASK, 8'h00);
    host.rd(OFF_SUPPLY_MASK, d);
    `CHK(d, 8'h00)
  endtask

  initial begin
    reset_n = 1'b0;
    ev = '0;
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_events();
    t_irq(OFF_WAKE_WD_MASK, 0, 8'h80);
    t_irq(OFF_SUPPLY_MASK, 9, 8'h02);
    t_set_wins();
    t_summary();
    t_reserved();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #(5000 * 25);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
